// *** core/dma_controller.sv ***
// six-channel direct memory access controller
//
// Functional notes
// - six channels, each with its own address, count and frame context
// - dma memory access wins over the processor access to internal memory
// - each channel high or low priority; round-robin within a level
// - source and destination updated separately: hold, increment, decrement, index
// - auto reload restores addresses and count from global registers after block
// - global reload registers are sampled only when a block completes
// - 8-bit frame count, zero means one frame, decremented on frame's last read
// - at block end with auto reload, frame count reloads from global frame reload
// - 16-bit element count decremented per element, once per pair in double-word; all ones means 65536 elements
// - with auto reload, element count reloads from global count reload at block end
// - double-word moves two 16-bit transfers per element, addresses updated each
// - non-last transfers of a frame add the selected element index
// - the last transfer of a frame adds the selected frame index instead
// - two element and two frame indexes shared, picked per channel select bits
// - interrupt enable off gives none; autobuffer: full, or half and full
// - multi-frame: block end only, or every frame end plus block end
// - 4-bit sync code picks the event; other codes reserved and never fire
// - 2-bit route select: 00 none, 01 channels 2,3, 10 channels 1,2,3
// - address map is fixed, independent of processor memory mode bits
`include "dma_map.svh"
module dma_controller
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // channel configuration
    input wire logic [`DMA_NUM_CH-1:0] channel_enable_i,
    input wire logic [`DMA_NUM_CH-1:0] channel_high_priority_i,
    input wire channel_mode_control_t [`DMA_NUM_CH-1:0] channel_mode_control_i,
    input wire logic [`DMA_NUM_CH-1:0] channel_load_i,
    input wire channel_context_t channel_load_value_i,
    input wire logic [1:0] interrupt_route_select_i,
    // shared index and reload registers
    input wire logic [15:0] element_index_a_i,
    input wire logic [15:0] element_index_b_i,
    input wire logic [15:0] frame_index_a_i,
    input wire logic [15:0] frame_index_b_i,
    input wire logic [15:0] global_source_reload_i,
    input wire logic [15:0] global_dest_reload_i,
    input wire logic [15:0] global_count_reload_i,
    input wire logic [7:0] global_frame_reload_i,
    // synchronization events, pulses from other clocking
    input wire logic port0_receive_event_i,
    input wire logic port0_transmit_event_i,
    input wire logic port1_receive_event_i,
    input wire logic port1_transmit_event_i,
    input wire logic timer0_event_i,
    input wire logic ext_int3_event_i,
    input wire logic timer1_event_i,
    // interrupt sources that share lines
    input wire logic timer1_interrupt_i,
    input wire logic port1_receive_interrupt_i,
    input wire logic port1_transmit_interrupt_i,
    // memory port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    output logic cpu_stall_o,
    input wire logic cpu_mem_req_i,
    // status and interrupts
    output logic [`DMA_NUM_CH-1:0] channel_busy_o,
    output logic [`DMA_NUM_CH-1:0] channel_interrupt_o,
    output logic [2:0] shared_line_o
);
    localparam int NCH = `DMA_NUM_CH;

    typedef struct packed {
        channel_context_t [NCH-1:0] ctx;
        logic [NCH-1:0] busy;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] half;
        logic [NCH-1:0] irq;
        logic [2:0] line;
        logic [NCH-1:0][15:0] total;
        xfer_state_t st;
        logic [2:0] cur;
        logic second;
        logic [6:0] ev_s1;
        logic [6:0] ev_s2;
        logic [6:0] ev_s3;
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic stall;
    } ctl_state_t;
    ctl_state_t s_q, s_d;

    // =========================
    // event synchronisers and sync select
    logic [6:0] ev_raw, ev_rise;
    assign ev_raw = {timer1_event_i, ext_int3_event_i, timer0_event_i,
                     port1_transmit_event_i, port1_receive_event_i,
                     port0_transmit_event_i, port0_receive_event_i};
    assign ev_rise = s_q.ev_s2 & ~s_q.ev_s3;

    logic [NCH-1:0] ev_hit, ready_ch;
    for (genvar c = 0; c < NCH; c++)
    begin : g_sync
        always_comb
        begin
            case (channel_mode_control_i[c].sync_event_select)
                `DMA_SYNC_P0_RX: ev_hit[c] = ev_rise[0];
                `DMA_SYNC_P0_TX: ev_hit[c] = ev_rise[1];
                `DMA_SYNC_P1_RX: ev_hit[c] = ev_rise[2];
                `DMA_SYNC_P1_TX: ev_hit[c] = ev_rise[3];
                `DMA_SYNC_TMR0: ev_hit[c] = ev_rise[4];
                `DMA_SYNC_XINT3: ev_hit[c] = ev_rise[5];
                `DMA_SYNC_TMR1: ev_hit[c] = ev_rise[6];
                default: ev_hit[c] = 1'b0;
            endcase
            // unsynced channels request every time
            ready_ch[c] = s_q.busy[c] && channel_enable_i[c] &&
                ((channel_mode_control_i[c].sync_event_select == `DMA_SYNC_NONE) ||
                 s_q.pend[c]);
        end
    end

    // =========================
    // arbiter and read/write buffer
    logic grant_valid, take;
    logic [2:0] grant;
    dma_arbiter u_arb (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .req_i(ready_ch),
        .high_i(channel_high_priority_i),
        .take_i(take),
        .grant_valid_o(grant_valid),
        .grant_o(grant)
    );

    logic buf_in_ready, buf_out_valid, buf_out_ready;
    mem_word_t buf_in, buf_out;
    dma_skid u_buf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(s_q.st == ST_WAIT),
        .in_data_i(buf_in),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_out_valid),
        .out_data_o(buf_out),
        .out_ready_i(buf_out_ready)
    );

    // =========================
    // address step
    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                         input logic [15:0] idx);
        case (m)
            `DMA_AM_INC: step = 16'(a + `DMA_ONE16);
            `DMA_AM_DEC: step = 16'(a - `DMA_ONE16);
            `DMA_AM_INDEX: step = 16'(a + idx);
            default: step = a;
        endcase
    endfunction : step

    channel_mode_control_t m;
    channel_context_t cx;
    logic last_elem, last_frame, last_xfer, frame_end;
    logic [15:0] s_idx, d_idx;
    always_comb
    begin
        m = channel_mode_control_i[s_q.cur];
        cx = s_q.ctx[s_q.cur];
        last_elem = cx.count == `DMA_ZERO16;
        last_frame = cx.frames == `DMA_ZERO8; // zero means a single frame
        last_xfer = last_elem && (!m.double_word || s_q.second);
        // selected index pair, frame index on the frame's last transfer
        s_idx = last_xfer ? (m.src_index_sel ? frame_index_b_i : frame_index_a_i)
                          : (m.src_index_sel ? element_index_b_i : element_index_a_i);
        d_idx = last_xfer ? (m.dst_index_sel ? frame_index_b_i : frame_index_a_i)
                          : (m.dst_index_sel ? element_index_b_i : element_index_a_i);
        frame_end = last_xfer;
        buf_in = '{addr: cx.dst, data: mem_rdata_i};
        // writes drain only while the read side is idle, keeping one port
        buf_out_ready = (s_q.st == ST_IDLE);
        take = (s_q.st == ST_IDLE) && grant_valid && !buf_out_valid;
    end

    // =========================
    // main sequencer
    always_comb
    begin
        s_d = s_q;
        s_d.ev_s1 = ev_raw;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ev_s3 = s_q.ev_s2;
        s_d.req = 1'b0;
        s_d.we = 1'b0;
        s_d.irq = '0;
        // dma goes first; the processor waits on any clash
        s_d.stall = 1'b0;
        for (int c = 0; c < NCH; c++)
        begin
            if (ev_hit[c])
                s_d.pend[c] = 1'b1; // event arms one element
            if (channel_load_i[c])
            begin
                s_d.ctx[c] = channel_load_value_i; // independent context
                s_d.busy[c] = 1'b1;
                s_d.half[c] = 1'b0;
                s_d.pend[c] = 1'b0;
                s_d.total[c] = channel_load_value_i.count;
            end
            if (!channel_enable_i[c])
                s_d.busy[c] = 1'b0;
        end
        case (s_q.st)
            ST_IDLE:
            begin
                if (buf_out_valid)
                begin
                    s_d.req = 1'b1;
                    s_d.we = 1'b1;
                    s_d.addr = buf_out.addr;
                    s_d.wdata = buf_out.data;
                    s_d.stall = cpu_mem_req_i;
                end
                else if (take)
                begin
                    s_d.cur = s_q.second ? s_q.cur : grant;
                    s_d.st = ST_READ;
                    s_d.req = 1'b1;
                    s_d.addr = s_q.ctx[s_d.cur].src; // fixed map, no mode bits
                    s_d.stall = cpu_mem_req_i;
                end
            end
            ST_READ:
                s_d.st = ST_WAIT;
            ST_WAIT:
            begin
                if (buf_in_ready)
                begin
                    s_d.st = ST_IDLE;
                    s_d.ctx[s_q.cur].src = step(cx.src, m.src_mode, s_idx);
                    s_d.ctx[s_q.cur].dst = step(cx.dst, m.dst_mode, d_idx);
                    if (m.double_word && !s_q.second)
                        s_d.second = 1'b1; // second half of the pair
                    else
                    begin
                        s_d.second = 1'b0;
                        if (m.sync_event_select != `DMA_SYNC_NONE)
                            s_d.pend[s_q.cur] = ev_hit[s_q.cur];
                        // one element per pair, count per pair
                        s_d.ctx[s_q.cur].count = 16'(cx.count - `DMA_ONE16);
                        if (m.autobuffering_mode && m.channel_interrupt_enable &&
                            m.interrupt_timing_mode && !s_q.half[s_q.cur] &&
                            cx.count == {1'b0, s_q.total[s_q.cur][15:1]})
                        begin
                            s_d.half[s_q.cur] = 1'b1;
                            s_d.irq[s_q.cur] = 1'b1; // half buffer
                        end
                        if (frame_end && !last_frame)
                        begin
                            s_d.ctx[s_q.cur].frames = 8'(cx.frames - 8'h01);
                            s_d.ctx[s_q.cur].count = s_q.total[s_q.cur];
                            if (m.channel_interrupt_enable && m.interrupt_timing_mode &&
                                !m.autobuffering_mode)
                                s_d.irq[s_q.cur] = 1'b1; // frame end
                        end
                        else if (frame_end)
                        begin
                            s_d.irq[s_q.cur] = m.channel_interrupt_enable;
                            s_d.half[s_q.cur] = 1'b0;
                            if (m.auto_reload_enable)
                            begin
                                // sampled only here
                                s_d.ctx[s_q.cur].src = global_source_reload_i;
                                s_d.ctx[s_q.cur].dst = global_dest_reload_i;
                                s_d.ctx[s_q.cur].count = global_count_reload_i;
                                s_d.total[s_q.cur] = global_count_reload_i;
                                s_d.ctx[s_q.cur].frames = global_frame_reload_i;
                            end
                            else
                                s_d.busy[s_q.cur] = 1'b0;
                        end
                    end
                end
            end
            default:
                s_d.st = ST_IDLE;
        endcase
        // lines shared with other sources
        case (interrupt_route_select_i)
            `DMA_ROUTE_CH23:
                s_d.line = {s_d.irq[3], s_d.irq[2], timer1_interrupt_i};
            `DMA_ROUTE_CH123:
                s_d.line = {s_d.irq[3], s_d.irq[2], s_d.irq[1]};
            default:
                s_d.line = {port1_transmit_interrupt_i, port1_receive_interrupt_i,
                            timer1_interrupt_i};
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    // =========================
    // outputs, all registered
    assign mem_req_o = s_q.req;
    assign mem_we_o = s_q.we;
    assign mem_addr_o = s_q.addr;
    assign mem_wdata_o = s_q.wdata;
    assign cpu_stall_o = s_q.stall;
    assign channel_busy_o = s_q.busy;
    assign channel_interrupt_o = s_q.irq;
    assign shared_line_o = s_q.line;
endmodule : dma_controller

// *** shared/dma_map.svh ***
// constant map for the six-channel dma controller
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH
`define DMA_NUM_CH 6
`define DMA_AW 16
`define DMA_DW 16
`define DMA_SYNC_NONE 4'h0
`define DMA_SYNC_P0_RX 4'h1
`define DMA_SYNC_P0_TX 4'h2
`define DMA_SYNC_P1_RX 4'h5
`define DMA_SYNC_P1_TX 4'h6
`define DMA_SYNC_TMR0 4'hd
`define DMA_SYNC_XINT3 4'he
`define DMA_SYNC_TMR1 4'hf
`define DMA_ROUTE_NONE 2'h0
`define DMA_ROUTE_CH23 2'h1
`define DMA_ROUTE_CH123 2'h2
`define DMA_AM_CONST 2'h0
`define DMA_AM_INC 2'h1
`define DMA_AM_DEC 2'h2
`define DMA_AM_INDEX 2'h3
`define DMA_ZERO16 16'h0000
`define DMA_ONE16 16'h0001
`define DMA_ZERO8 8'h00
`endif

// *** shared/dma_pkg.sv ***
// types for the six-channel dma controller
package dma_pkg;
    typedef struct packed {
        logic [1:0] src_mode;
        logic [1:0] dst_mode;
        logic src_index_sel;
        logic dst_index_sel;
        logic auto_reload_enable;
        logic channel_interrupt_enable;
        logic interrupt_timing_mode;
        logic autobuffering_mode;
        logic double_word;
        logic [3:0] sync_event_select;
    } channel_mode_control_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] count;
        logic [7:0] frames;
    } channel_context_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mem_word_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_WRITE = 4'b1000
    } xfer_state_t;
endpackage : dma_pkg

// *** core/dma_arbiter.sv ***
// two-level round-robin arbiter over the dma channels
`include "dma_map.svh"
module dma_arbiter
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // requests
    input wire logic [`DMA_NUM_CH-1:0] req_i,
    input wire logic [`DMA_NUM_CH-1:0] high_i,
    input wire logic take_i,
    // grant
    output logic grant_valid_o,
    output logic [2:0] grant_o
);
    typedef struct packed {
        logic [2:0] last_hi;
        logic [2:0] last_lo;
    } arb_state_t;
    arb_state_t s_q, s_d;

    // =========================
    // search from the last served channel of each level
    function automatic logic [3:0] pick(input logic [`DMA_NUM_CH-1:0] r,
                                        input logic [2:0] last);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int k = `DMA_NUM_CH; k >= 1; k--)
        begin
            idx = 3'((int'(last) + k) % `DMA_NUM_CH);
            if (r[idx])
                res = {1'b1, idx};
        end
        return res;
    endfunction : pick

    logic [3:0] hi_pick, lo_pick;
    always_comb
    begin
        hi_pick = pick(req_i & high_i, s_q.last_hi);
        lo_pick = pick(req_i & ~high_i, s_q.last_lo);
        grant_valid_o = hi_pick[3] | lo_pick[3];
        grant_o = hi_pick[3] ? hi_pick[2:0] : lo_pick[2:0]; // high level first
        s_d = s_q;
        if (take_i && hi_pick[3])
            s_d.last_hi = hi_pick[2:0]; // rotate within level
        else if (take_i && lo_pick[3])
            s_d.last_lo = lo_pick[2:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_q <= '{last_hi: 3'h5, last_lo: 3'h5};
        else
            s_q <= s_d;
    end
endmodule : dma_arbiter

// *** core/dma_skid.sv ***
// two-entry buffer holding words read and not yet written
module dma_skid
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic in_valid_i,
    input wire mem_word_t in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output mem_word_t out_data_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        mem_word_t [1:0] mem;
        logic [1:0] cnt;
        logic rd;
        logic wr;
    } skid_state_t;
    skid_state_t s_q, s_d;

    logic push, pop;
    always_comb
    begin
        in_ready_o = s_q.cnt != 2'h2;
        out_valid_o = s_q.cnt != 2'h0;
        out_data_o = s_q.mem[s_q.rd];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr = ~s_q.wr;
        end
        if (pop)
            s_d.rd = ~s_q.rd;
        s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule : dma_skid

// *** tb/dma_mem_model.sv ***
// memory partner model answering the dma memory port
module dma_mem_model (
    // memory port
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [256];
    int hold = 0;
    // ==========================================
    // storage and read answer
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 16'(i) ^ 16'ha5c3;
        rdata_o = 16'h0000;
    end
    always @(posedge clk_i)
    begin
        if (req_i && we_i)
            mem[addr_i[7:0]] <= wdata_i;
        if (req_i && !we_i)
        begin
            rdata_o <= mem[addr_i[7:0]];
            hold <= 2;
        end
        else if (hold > 1)
            hold <= hold - 1;
        else
            rdata_o <= ~rdata_o; // released: no stale word
    end
endmodule : dma_mem_model

// *** tb/dma_controller_monitor.sv ***
// port assertions for the dma controller
`include "dma_map.svh"
module dma_controller_monitor
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // inputs
    input wire logic [`DMA_NUM_CH-1:0] channel_enable_i,
    input wire logic [`DMA_NUM_CH-1:0] channel_load_i,
    input wire channel_mode_control_t [`DMA_NUM_CH-1:0] channel_mode_control_i,
    input wire logic [1:0] interrupt_route_select_i,
    input wire logic timer1_interrupt_i,
    input wire logic port1_receive_interrupt_i,
    input wire logic port1_transmit_interrupt_i,
    input wire logic cpu_mem_req_i,
    // outputs
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic cpu_stall_o,
    input wire logic [`DMA_NUM_CH-1:0] channel_busy_o,
    input wire logic [`DMA_NUM_CH-1:0] channel_interrupt_o,
    input wire logic [2:0] shared_line_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`DMA_NUM_CH-1:0] ie;
    // ==========================================
    // helpers
    always_comb
    begin
        for (int i = 0; i < `DMA_NUM_CH; i++)
            ie[i] = channel_mode_control_i[i].channel_interrupt_enable;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_rd;
        mem_req_o && !mem_we_o;
    endsequence
    sequence s_wr;
        mem_req_o && mem_we_o;
    endsequence
    // ==========================================
    // properties
    AST_READ_WRITE: assert property (s_rd |=> !mem_req_o [*2] ##[1:2] s_wr)
        else $error("read not followed by its write");
    AST_STALL: assert property (cpu_stall_o == (mem_req_o && $past(cpu_mem_req_i)))
        else $error("stall without dma access");
    AST_IRQ_OFF: assert property ((channel_interrupt_o & ~ie) == '0)
        else $error("interrupt from disabled channel");
    AST_LOAD_BUSY: assert property (|(channel_load_i & channel_enable_i) |=>
        (channel_busy_o & $past(channel_load_i)) == $past(channel_load_i))
        else $error("loaded channel not busy");
    AST_ABORT: assert property (channel_enable_i != '1 |=>
        (channel_busy_o & ~$past(channel_enable_i)) == '0)
        else $error("disabled channel still busy");
    AST_ROUTE_OFF: assert property ($past(rst_b_i) &&
        $past(interrupt_route_select_i[0]) == $past(interrupt_route_select_i[1]) |->
        shared_line_o == $past({port1_transmit_interrupt_i,
        port1_receive_interrupt_i, timer1_interrupt_i}))
        else $error("shared lines wrong for route none");
    AST_ROUTE_23: assert property ($past(interrupt_route_select_i) == 2'h1 |->
        shared_line_o == {channel_interrupt_o[3:2], $past(timer1_interrupt_i)})
        else $error("shared lines wrong for route 01");
    AST_ROUTE_123: assert property ($past(interrupt_route_select_i) == 2'h2 |->
        shared_line_o == channel_interrupt_o[3:1])
        else $error("shared lines wrong for route 10");
endmodule : dma_controller_monitor
bind dma_controller dma_controller_monitor u_mon (.clk_i, .rst_b_i, .channel_enable_i,
    .channel_load_i, .channel_mode_control_i, .interrupt_route_select_i, .timer1_interrupt_i,
    .port1_receive_interrupt_i, .port1_transmit_interrupt_i, .cpu_mem_req_i, .mem_req_o,
    .mem_we_o, .cpu_stall_o, .channel_busy_o, .channel_interrupt_o, .shared_line_o);

// *** tb/six_channel_dma_controller_tb_top.sv ***
// self-checking bench for the six-channel dma controller
`include "dma_map.svh"
module six_channel_dma_controller_tb_top import dma_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [5:0] en = '1, hp = 6'h0a, ld = '0, busy, irq;
    channel_mode_control_t [5:0] md = '0;
    channel_context_t val = '0;
    logic [1:0] rt = 2'h0;
    logic [15:0] gs = '0, gd = '0, gc = '0, rd, ad, wd;
    logic [7:0] gf = '0;
    logic [6:0] ev = '0;
    logic [2:0] sh = 3'h7, line;
    logic cpu = 1'b0, req, we, stall;
    logic [15:0] so [4] = '{16'h0, 16'h3, 16'hc, 16'hf};
    logic [3:0] code [7] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hd, 4'he, 4'hf};
    int error_cnt = 0, tests_run = 0, irqs = 0, k;
    // ==========================================
    // clock, design and partner
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) irqs <= irqs + int'(irq[2]) + int'(line[1]);
    dma_controller u_dut (.clk_i, .rst_b_i, .channel_enable_i(en), .channel_high_priority_i(hp),
        .channel_mode_control_i(md), .channel_load_i(ld), .channel_load_value_i(val),
        .interrupt_route_select_i(rt), .element_index_a_i(16'h0002),
        .element_index_b_i(16'h0003), .frame_index_a_i(16'h0005), .frame_index_b_i(16'h0009),
        .global_source_reload_i(gs), .global_dest_reload_i(gd), .global_count_reload_i(gc),
        .global_frame_reload_i(gf), .port0_receive_event_i(ev[0]), .port0_transmit_event_i(ev[1]),
        .port1_receive_event_i(ev[2]), .port1_transmit_event_i(ev[3]), .timer0_event_i(ev[4]),
        .ext_int3_event_i(ev[5]), .timer1_event_i(ev[6]), .timer1_interrupt_i(sh[0]),
        .port1_receive_interrupt_i(sh[1]), .port1_transmit_interrupt_i(sh[2]), .mem_req_o(req),
        .mem_we_o(we), .mem_addr_o(ad), .mem_wdata_o(wd), .mem_rdata_i(rd), .cpu_stall_o(stall),
        .cpu_mem_req_i(cpu), .channel_busy_o(busy), .channel_interrupt_o(irq),
        .shared_line_o(line));
    dma_mem_model u_mem (.clk_i, .req_i(req), .we_i(we), .addr_i(ad), .wdata_i(wd), .rdata_o(rd));
    // ==========================================
    // tasks
    function automatic logic [15:0] pat(input logic [15:0] a);
        return a ^ 16'ha5c3;
    endfunction : pat
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic load(input int c, input logic [15:0] s, input logic [15:0] d,
        input logic [15:0] n);
        val = '{s, d, n, 8'h00};
        val.frames = (c == 2) ? 8'h01 : 8'h00;
        ld[c] = 1'b1;
        tick(1);
        ld = '0;
    endtask : load
    task automatic idle(input int c);
        int w;
        w = 0;
        while (busy[c] !== 1'b0 && w < 3000)
        begin
            tick(1);
            w++;
        end
        tick(2);
        check("busy", {15'h0, busy[c]}, 16'h0);
    endtask : idle
    task automatic mem(input logic [15:0] d, input logic [15:0] s);
        check("mem", u_mem.mem[d[7:0]], pat(s));
    endtask : mem
    // ==========================================
    // tests
    initial
    begin
        #(4 * 25000);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        tick(3);
        rst_b_i = 1'b1;
        md[0].src_mode = `DMA_AM_INC;
        md[0].dst_mode = `DMA_AM_INC;
        load(0, 16'h0010, 16'h0080, 16'h0003);
        idle(0);
        for (int i = 0; i < 5; i++)
            mem(16'(16'h80 + i), 16'(i < 4 ? 16'h10 + i : 16'h84));
        md[1].src_mode = `DMA_AM_DEC;
        cpu = 1'b1;
        load(1, 16'h0013, 16'h0088, 16'h0002);
        idle(1);
        cpu = 1'b0;
        mem(16'h0088, 16'h0011);
        mem(16'h0089, 16'h0089);
        md[2].src_mode = `DMA_AM_INDEX;
        md[2].src_index_sel = 1'b1;
        md[2].dst_mode = `DMA_AM_INC;
        sh = 3'h1;
        for (int n = 0; n < 4; n++)
        begin
            md[2].channel_interrupt_enable = (n != 1);
            {md[2].interrupt_timing_mode, md[2].autobuffering_mode} = {n >= 2, n == 3};
            rt = (n == 1) ? 2'h2 : 2'h1;
            load(2, 16'h0040, 16'(16'ha0 + 4 * n), 16'h0001);
            k = irqs;
            idle(2);
            for (int j = 0; j < 4; j++)
                mem(16'(16'ha0 + 4 * n + j), 16'h40 + so[j]);
            check("irqs", 16'(irqs - k), 16'(n == 1 ? 0 : n ? 4 : 2));
            check("line", 16'(line), 16'(n != 1));
        end
        md[4].src_mode = `DMA_AM_INC;
        md[4].dst_mode = `DMA_AM_INC;
        md[4].double_word = 1'b1;
        load(4, 16'h0050, 16'h00b0, 16'h0000);
        idle(4);
        for (int i = 0; i < 3; i++)
            mem(16'(16'hb0 + i), 16'(i < 2 ? 16'h50 + i : 16'hb2));
        for (int c = 0; c < 7; c++)
        begin
            md[5].sync_event_select = code[c];
            load(5, 16'(16'h60 + c), 16'(16'hc0 + c), 16'h0000);
            ev = 7'h7f & ~(7'h01 << c);
            tick(3);
            ev = '0;
            tick(20);
            mem(16'(16'hc0 + c), 16'(16'hc0 + c));
            ev = 7'h01 << c;
            tick(3);
            ev = '0;
            idle(5);
            mem(16'(16'hc0 + c), 16'(16'h60 + c));
        end
        md[5].sync_event_select = 4'h3;
        load(5, 16'h0070, 16'h00c8, 16'h0000);
        ev = 7'h7f;
        tick(30);
        ev = '0;
        mem(16'h00c8, 16'h00c8);
        en[5] = 1'b0;
        tick(2);
        check("abort", {15'h0, busy[5]}, 16'h0);
        en[5] = 1'b1;
        md[3].src_mode = `DMA_AM_INC;
        md[3].dst_mode = `DMA_AM_INC;
        md[3].auto_reload_enable = 1'b1;
        load(3, 16'h0020, 16'h00d0, 16'h0001);
        {gs, gd, gc} = {16'h0030, 16'h00e0, 16'h0000};
        k = 0;
        while (u_mem.mem[8'he0] !== pat(16'h0030) && k < 500)
        begin
            tick(1);
            k++;
        end
        md[3].auto_reload_enable = 1'b0;
        idle(3);
        mem(16'h00d1, 16'h0021);
        mem(16'h00e0, 16'h0030);
        mem(16'h00e1, 16'h00e1);
        complete_run();
    end
endmodule : six_channel_dma_controller_tb_top
